// ---- src/pwd_pkg.sv ----
package pwd_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_CFG       = 16'hf020;
    localparam logic [15:0] IDX_PRESCALER = 16'hf021;
    localparam logic [15:0] IDX_WRAP      = 16'hf022;
    localparam logic [15:0] IDX_COUNTDOWN = 16'hf023;
    localparam logic [15:0] IDX_STATUS    = 16'hf024;

    localparam int ADDR_W    = 18;
    localparam int PRESC_W   = 16;
    localparam int COUNT_W   = 12;

    // Field positions
    localparam int CFG_COUNT_BIT   = 0;
    localparam int CFG_TRIGGER_BIT = 1;
    localparam int STATUS_BIT      = 0;

    // Reset values, then step and zero constants
    localparam logic [PRESC_W-1:0] WRAP_RST      = 16'hffff;
    localparam logic [PRESC_W-1:0] PRESC_RST     = 16'h0000;
    localparam logic [COUNT_W-1:0] COUNTDOWN_RST = 12'hfff;
    localparam logic [PRESC_W-1:0] PRESC_ONE     = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_ONE     = 12'h001;
    localparam logic [COUNT_W-1:0] COUNT_ZERO    = 12'h000;

    // Configuration bits
    typedef struct packed {
        logic trigger_en;
        logic count_en;
    } pwd_cfg_type;

    // Classic Wishbone request
    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADDR_W-1:0] adr;
        logic [31:0]       dat;
        logic [3:0]        sel;
    } pwd_wb_req_type;

endpackage : pwd_pkg

// ---- src/pwd_top.sv ----
// Operation
// - Prescaler divides oscillator input by wrap value plus one, giving the tick.
// - Wrap value is read/write and resets to 0xffff.
// - 12-bit countdown decrements by one on each prescaler wrap, holding at zero.
// - Countdown reaching zero resets the chip when triggering is enabled.
// - Software write to countdown loads the value counted down from.
// - Read-only status flag goes to one when the watchdog fired a reset.
// - Status flag survives watchdog reset; only power-on reset clears it.
// - Count and trigger enables reset off; each needed for its function.
// - Prescaler increments per oscillator edge, readable, wraps to zero.
`timescale 1ns/1ps
`default_nettype none

module pwd_top (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      por_i,
    input  wire logic                      oscillator_input_i,
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [pwd_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]               wb_dat_i,
    input  wire logic [3:0]                wb_sel_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    output logic                           chip_reset_o
);

    pwd_pkg::pwd_wb_req_type req;
    pwd_pkg::pwd_cfg_type    cfg;
    pwd_pkg::pwd_cfg_type    next_cfg;
    logic [pwd_pkg::PRESC_W-1:0] presc;
    logic [pwd_pkg::PRESC_W-1:0] next_presc;
    logic [pwd_pkg::PRESC_W-1:0] wrap;
    logic [pwd_pkg::PRESC_W-1:0] next_wrap;
    logic [pwd_pkg::COUNT_W-1:0] countdown;
    logic [pwd_pkg::COUNT_W-1:0] next_countdown;
    logic                        status;
    logic                        next_status;
    logic                        osc_prev;
    logic                        next_chip_reset;
    logic                        next_ack;
    logic [31:0]                 next_rdata;
    logic                        osc_edge;
    logic                        tick;
    logic                        wr_commit;
    logic                        wr_count;
    logic                        fire;

    // Merge write data into a register under the byte lanes
    function automatic logic [31:0] apply_lanes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : apply_lanes

    // Register index match on the word address
    function automatic logic hit(input logic [pwd_pkg::ADDR_W-1:0] adr,
                                 input logic [15:0]               idx);
        return adr[pwd_pkg::ADDR_W-1:2] == idx;
    endfunction : hit

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   adr: wb_adr_i, dat: wb_dat_i, sel: wb_sel_i};

    // Writes land on the edge where the master sees ack
    assign wr_commit = req.cyc & req.stb & req.we & wb_ack_o;
    assign wr_count  = wr_commit & hit(req.adr, pwd_pkg::IDX_COUNTDOWN);

    // Input is synchronous, so a plain edge detect is safe
    assign osc_edge = oscillator_input_i & ~osc_prev;
    assign tick     = osc_edge & cfg.count_en & (presc == wrap);
    // A kick in the same cycle wins, so a late rewrite still saves the chip
    assign fire = tick & cfg.trigger_en & ~wr_count
                & (countdown == pwd_pkg::COUNT_ONE);

    // Bus answer: one wait state, ack dropped after one cycle
    always_comb begin
        next_ack   = req.cyc & req.stb & ~wb_ack_o;
        next_rdata = 32'h0000_0000; // Unmapped words read zero
        if (hit(req.adr, pwd_pkg::IDX_CFG)) begin
            next_rdata[pwd_pkg::CFG_COUNT_BIT]   = cfg.count_en;
            next_rdata[pwd_pkg::CFG_TRIGGER_BIT] = cfg.trigger_en;
        end else if (hit(req.adr, pwd_pkg::IDX_PRESCALER)) begin
            next_rdata[pwd_pkg::PRESC_W-1:0] = presc;
        end else if (hit(req.adr, pwd_pkg::IDX_WRAP)) begin
            next_rdata[pwd_pkg::PRESC_W-1:0] = wrap;
        end else if (hit(req.adr, pwd_pkg::IDX_COUNTDOWN)) begin
            next_rdata[pwd_pkg::COUNT_W-1:0] = countdown;
        end else if (hit(req.adr, pwd_pkg::IDX_STATUS)) begin
            next_rdata[pwd_pkg::STATUS_BIT] = status;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_rdata;
        end
    end

    // Timer state and software writes
    always_comb begin
        logic [31:0] merged;
        merged          = 32'h0000_0000;
        next_cfg        = cfg;
        next_presc      = presc;
        next_wrap       = wrap;
        next_countdown  = countdown;
        next_status     = status | fire;
        next_chip_reset = fire;
        if (osc_edge && cfg.count_en) begin
            if (presc == wrap) begin
                next_presc = pwd_pkg::PRESC_RST;
                if (countdown != pwd_pkg::COUNT_ZERO) begin
                    next_countdown = countdown - pwd_pkg::COUNT_ONE;
                end
            end else begin
                next_presc = presc + pwd_pkg::PRESC_ONE;
            end
        end
        if (wr_commit) begin
            if (hit(req.adr, pwd_pkg::IDX_CFG)) begin
                merged = apply_lanes({30'h0000_0000, cfg.trigger_en,
                                      cfg.count_en}, req.dat, req.sel);
                next_cfg.count_en   = merged[pwd_pkg::CFG_COUNT_BIT];
                next_cfg.trigger_en = merged[pwd_pkg::CFG_TRIGGER_BIT];
            end else if (hit(req.adr, pwd_pkg::IDX_WRAP)) begin
                merged = apply_lanes({16'h0000, wrap}, req.dat, req.sel);
                next_wrap = merged[pwd_pkg::PRESC_W-1:0];
            end else if (hit(req.adr, pwd_pkg::IDX_COUNTDOWN)) begin
                merged = apply_lanes({20'h00000, countdown}, req.dat,
                                     req.sel);
                next_countdown = merged[pwd_pkg::COUNT_W-1:0];
            end
        end
    end

    // Status sits outside the chip reset so the cause survives it
    always_ff @(posedge clk_i) begin
        if (rst_i || por_i) begin
            cfg          <= '0;
            presc        <= pwd_pkg::PRESC_RST;
            wrap         <= pwd_pkg::WRAP_RST;
            countdown    <= pwd_pkg::COUNTDOWN_RST;
            osc_prev     <= 1'b0;
            chip_reset_o <= 1'b0;
        end else begin
            cfg          <= next_cfg;
            presc        <= next_presc;
            wrap         <= next_wrap;
            countdown    <= next_countdown;
            osc_prev     <= oscillator_input_i;
            chip_reset_o <= next_chip_reset;
        end
        if (por_i) begin
            status <= 1'b0;
        end else if (!rst_i) begin
            status <= next_status;
        end
    end

    // Bus and timer checks, all sampled on the system clock

    a_wrap_after_reset: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        $past(rst_i) |-> wrap == pwd_pkg::WRAP_RST)
        else $error("Wrap value not at reset value");

    // A forgotten enable must not leave the watchdog armed after reset
    a_enables_off_reset: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        $past(rst_i) |-> !cfg.count_en && !cfg.trigger_en)
        else $error("Enables not off after reset");

    // One step per enabled oscillator edge below the wrap value
    a_presc_counts_up: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        osc_edge && cfg.count_en && presc != wrap
        |=> presc == $past(presc) + pwd_pkg::PRESC_ONE)
        else $error("Prescaler did not advance");

    // Wrap restarts the divider so the period is wrap plus one
    a_presc_wraps_zero: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        tick |=> presc == pwd_pkg::PRESC_RST)
        else $error("Prescaler did not wrap to zero");

    // Each divider wrap takes exactly one off a nonzero countdown
    a_count_decrements: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        tick && !wr_count && countdown != pwd_pkg::COUNT_ZERO
        |=> countdown == $past(countdown) - pwd_pkg::COUNT_ONE)
        else $error("Countdown did not decrement on wrap");

    // A full-lane write lands the new timeout as written
    a_count_loads: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        wr_count && req.sel[1:0] == 2'h3
        |=> countdown == $past(req.dat[pwd_pkg::COUNT_W-1:0]))
        else $error("Countdown write not loaded");

    // A spurious pulse would reset the whole chip, so demand its cause
    a_fire_has_cause: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        chip_reset_o |-> $past(cfg.trigger_en) && $past(tick)
            && $past(countdown) == pwd_pkg::COUNT_ONE
            && countdown == pwd_pkg::COUNT_ZERO)
        else $error("Chip reset without expiry");

    // The cause must be visible to software after the restart
    a_fire_sets_status: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        chip_reset_o |-> status ##1 status)
        else $error("Status not set by firing");

    // Chip reset must not wipe the record of why it happened
    a_status_survives: assert property (@(posedge clk_i)
        disable iff (por_i)
        status |=> status)
        else $error("Status cleared without power-on reset");

    // Debug freeze: a stopped timer neither moves nor fires
    a_hold_disabled: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        !cfg.count_en && !wr_commit
        |=> $stable(presc) && $stable(countdown) && !chip_reset_o)
        else $error("Timer moved while count disabled");

    // A held ack would commit a write twice
    a_ack_one_cycle: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("Ack held longer than one cycle");

    // Trigger enable gates the reset even when the count expires
    a_fire_needs_trig: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        tick && !cfg.trigger_en |=> !chip_reset_o)
        else $error("Chip reset with trigger disabled");

    // A kick on the expiry edge must win over the firing
    a_kick_wins: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        wr_count |=> !chip_reset_o)
        else $error("Chip reset despite countdown write");

    // Zero is a resting state, so an expired timer never fires again
    a_zero_holds: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        countdown == pwd_pkg::COUNT_ZERO && !wr_count
        |=> countdown == pwd_pkg::COUNT_ZERO && !chip_reset_o)
        else $error("Countdown left zero without a write");

    // One expiry gives one reset pulse
    a_pulse_single: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        chip_reset_o |=> !chip_reset_o)
        else $error("Chip reset pulse longer than one cycle");

    // Wrap only changes under a bus write to it
    a_wrap_write_only: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        !(wr_commit && hit(req.adr, pwd_pkg::IDX_WRAP)) |=> $stable(wrap))
        else $error("Wrap value changed without a write");

    // Enables only change under a bus write
    a_cfg_write_only: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        !wr_commit |=> $stable(cfg))
        else $error("Enables changed without a write");

    // Power-on reset alone clears the fired flag
    a_por_clears: assert property (@(posedge clk_i)
        por_i |=> !status)
        else $error("Status not cleared by power-on reset");

    // Ack only answers a request that was on the bus
    a_ack_has_req: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        wb_ack_o |-> $past(req.cyc && req.stb))
        else $error("Ack without a request");

    // Flag only rises together with the reset pulse
    a_status_cause: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        $rose(status) |-> chip_reset_o)
        else $error("Status set without a chip reset");

    // Prescaler moves only on an enabled oscillator edge
    a_presc_idle: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        !(osc_edge && cfg.count_en) |=> $stable(presc))
        else $error("Prescaler moved without an edge");

    // Countdown moves only on a wrap or a write
    a_count_idle: assert property (@(posedge clk_i)
        disable iff (rst_i || por_i)
        !tick && !wr_count |=> $stable(countdown))
        else $error("Countdown moved without a wrap");

endmodule : pwd_top

`default_nettype wire

// ---- test/pwd_top_bench.sv ----
`timescale 1ns/1ps
`default_nettype none

module pwd_top_bench;
    logic                    clk_i;
    logic                    rst_i;
    logic                    por_i;
    logic                    osc;
    pwd_pkg::pwd_wb_req_type req;
    logic [31:0]             wb_dat_o;
    logic                    wb_ack_o;
    logic                    chip_reset_o;
    logic [31:0]             rdata;
    logic [3:0]              lanes;
    int                      fails;
    int                      checked;
    int                      fires;

    pwd_top dut_u (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .por_i              (por_i),
        .oscillator_input_i (osc),
        .wb_cyc_i           (req.cyc),
        .wb_stb_i           (req.stb),
        .wb_we_i            (req.we),
        .wb_adr_i           (req.adr),
        .wb_dat_i           (req.dat),
        .wb_sel_i           (req.sel),
        .wb_dat_o           (wb_dat_o),
        .wb_ack_o           (wb_ack_o),
        .chip_reset_o       (chip_reset_o)
    );

    // Bench clock, 50 ns period
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Count every pulse so a doubled or missing one shows
    always @(posedge clk_i) begin
        if (chip_reset_o === 1'b1)
            fires <= fires + 1;
    end

    task automatic print_verdict;
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Classic cycle; held until ack is sampled, then a quiet cycle
    task automatic wb(input logic we, input logic [15:0] idx,
                      input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, {idx, 2'h0}, wd, lanes};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            fails++;
            print_verdict();
        end else begin
            rdata = wb_dat_o;
            req <= '0;
            @(posedge clk_i);
        end
    endtask : wb

    task automatic rd(input string name, input logic [15:0] idx,
                      input logic [31:0] exp);
        wb(1'b0, idx, 32'h0);
        chk(name, exp, rdata);
    endtask : rd

    // Each pulse is one rising oscillator edge; two edges to settle
    task automatic osc_edges(input int k);
        repeat (k) begin
            @(posedge clk_i);
            osc <= 1'b1;
            @(posedge clk_i);
            osc <= 1'b0;
        end
        repeat (2) @(posedge clk_i);
    endtask : osc_edges

    initial begin
        rst_i = 1'b1;
        por_i = 1'b1;
        osc = 1'b0;
        req = '0;
        lanes = 4'hf;
        fails = 0;
        checked = 0;
        fires = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
        rd("cfg", pwd_pkg::IDX_CFG, 32'h0);
        rd("wrap", pwd_pkg::IDX_WRAP, 32'h0000ffff);
        rd("prescaler", pwd_pkg::IDX_PRESCALER, 32'h0);
        rd("status", pwd_pkg::IDX_STATUS, 32'h0);
        rd("unmapped", 16'hf030, 32'h0);
        // Upper bits must be dropped on write
        wb(1'b1, pwd_pkg::IDX_WRAP, 32'habcd0002);
        rd("wrap", pwd_pkg::IDX_WRAP, 32'h00000002);
        wb(1'b1, pwd_pkg::IDX_COUNTDOWN, 32'h00000003);
        osc_edges(2);
        rd("prescaler", pwd_pkg::IDX_PRESCALER, 32'h0);
        rd("countdown", pwd_pkg::IDX_COUNTDOWN, 32'h3);
        // Count only: period is wrap plus one edges, no firing
        wb(1'b1, pwd_pkg::IDX_CFG, 32'h1);
        osc_edges(2);
        rd("prescaler", pwd_pkg::IDX_PRESCALER, 32'h2);
        osc_edges(1);
        rd("prescaler", pwd_pkg::IDX_PRESCALER, 32'h0);
        rd("countdown", pwd_pkg::IDX_COUNTDOWN, 32'h2);
        osc_edges(6);
        rd("countdown", pwd_pkg::IDX_COUNTDOWN, 32'h0);
        chk("fires", 32'h0, fires);
        // Armed: fires exactly on reaching zero
        wb(1'b1, pwd_pkg::IDX_WRAP, 32'h0);
        wb(1'b1, pwd_pkg::IDX_COUNTDOWN, 32'h2);
        wb(1'b1, pwd_pkg::IDX_CFG, 32'h3);
        osc_edges(1);
        chk("fires", 32'h0, fires);
        osc_edges(1);
        chk("fires", 32'h1, fires);
        rd("status", pwd_pkg::IDX_STATUS, 32'h1);
        // Regular rewrites keep it from firing again
        repeat (3) begin
            wb(1'b1, pwd_pkg::IDX_COUNTDOWN, 32'h2);
            osc_edges(1);
        end
        chk("fires", 32'h1, fires);
        // Chip reset keeps the flag, power-on clears it
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd("status", pwd_pkg::IDX_STATUS, 32'h1);
        rd("cfg", pwd_pkg::IDX_CFG, 32'h0);
        rd("countdown", pwd_pkg::IDX_COUNTDOWN, 32'h00000fff);
        por_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        por_i <= 1'b0;
        rd("status", pwd_pkg::IDX_STATUS, 32'h0);
        // One byte lane writes only the low byte of the wrap value
        lanes = 4'h1;
        wb(1'b1, pwd_pkg::IDX_WRAP, 32'h00001201);
        lanes = 4'hf;
        rd("wrap", pwd_pkg::IDX_WRAP, 32'h0000ff01);
        // Prescaler and status ignore writes
        wb(1'b1, pwd_pkg::IDX_PRESCALER, 32'h00000005);
        rd("prescaler", pwd_pkg::IDX_PRESCALER, 32'h0);
        wb(1'b1, pwd_pkg::IDX_STATUS, 32'h00000001);
        rd("status", pwd_pkg::IDX_STATUS, 32'h0);
        // Trigger without count never moves or fires
        wb(1'b1, pwd_pkg::IDX_WRAP, 32'h0);
        wb(1'b1, pwd_pkg::IDX_COUNTDOWN, 32'h1);
        wb(1'b1, pwd_pkg::IDX_CFG, 32'h2);
        osc_edges(2);
        rd("countdown", pwd_pkg::IDX_COUNTDOWN, 32'h1);
        chk("fires", 32'h1, fires);
        // A countdown parked at zero stays silent
        wb(1'b1, pwd_pkg::IDX_COUNTDOWN, 32'h0);
        wb(1'b1, pwd_pkg::IDX_CFG, 32'h3);
        osc_edges(2);
        rd("countdown", pwd_pkg::IDX_COUNTDOWN, 32'h0);
        chk("fires", 32'h1, fires);
        // Kick committed on the very expiry edge wins
        wb(1'b1, pwd_pkg::IDX_COUNTDOWN, 32'h1);
        fork
            wb(1'b1, pwd_pkg::IDX_COUNTDOWN, 32'h2);
            begin
                repeat (2) @(posedge clk_i);
                osc <= 1'b1;
                @(posedge clk_i);
                osc <= 1'b0;
            end
        join
        rd("countdown", pwd_pkg::IDX_COUNTDOWN, 32'h2);
        chk("fires", 32'h1, fires);
        // Left alone it expires and fires once more
        osc_edges(2);
        chk("fires", 32'h2, fires);
        rd("status", pwd_pkg::IDX_STATUS, 32'h1);
        print_verdict();
    end
endmodule : pwd_top_bench

`default_nettype wire
